// [logic/dac_spi_defs.svh]
// constants of the serial register front end: offsets, bit positions,
// reset values and the address wrap point.
// assumes inclusion by bare name from the design files.
`ifndef DAC_SPI_DEFS_SVH
`define DAC_SPI_DEFS_SVH

// ============================================================
// register offsets
`define OFS_CFG_A 15'h0000
`define OFS_CFG_B 15'h0001
`define OFS_CFG_C 15'h0002
`define OFS_STATUS 15'h0003
`define OFS_REF_CFG 15'h0004
`define OFS_POWER 15'h0005
`define OFS_MAKER_LSB 15'h000c
`define OFS_MAKER_MSB 15'h000d
`define OFS_DAC_LSB 15'h0029
`define OFS_DAC_MSB 15'h002a
`define OFS_TOP 15'h004b

// ============================================================
// field positions
`define POS_ADDR_ASC 5
`define POS_SINGLE_INSTR 7
`define POS_SHORT_INSTR 3
`define POS_WRITE_LOCK 5
`define POS_BIT_COUNT_FAULT 4
`define POS_INCOMPLETE_FAULT 2
`define POS_SHUTDOWN 0

// ============================================================
// reset values
`define RST_ADDR_ASC 1'b0
`define RST_SINGLE_INSTR 1'b0
`define RST_SHORT_INSTR 1'b1
`define RST_REF_SEL 2'b00
`define RST_SHUTDOWN 1'b0
`define RST_DAC_CODE 16'h0000

// ============================================================
// instruction and data byte lengths, last bit index
`define LAST_BIT_SHORT 4'h7
`define LAST_BIT_LONG 4'hf
`define LAST_BIT_BYTE 4'h7

`endif

// [logic/dac_spi_pkg.sv]
// types shared by the serial register front end.
// assumes nothing beyond a SystemVerilog compiler.
package dac_spi_pkg;
    // frame sequencing states
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_instr = 2'b01,
        st_data = 2'b10
    } frame_state_e;
endpackage

// [logic/pin_sync.sv]
// two-flop synchroniser plus one delay stage for edge finding.
// assumes asynchronous pin inputs and an active-low reset.
`timescale 1ns/100ps
module pin_sync #(
    parameter int W = 3,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] lvl,
    output logic [W-1:0] prev
);
    logic [W-1:0] meta;

    // ============================================================
    // meta stage feeds only the second flop
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta <= RST_VAL;
            lvl <= RST_VAL;
            prev <= RST_VAL;
        end else begin
            meta <= pin;
            lvl <= meta;
            prev <= lvl;
        end
    end
endmodule // pin_sync

// [logic/dac_spi_register_access.sv]
// serial register front end of a single-channel voltage dac.
// assumes a host driving cs_n, sclk and sdi in mode 0 (sample on rise),
// sclk well below a quarter of clk.
// How it works
// - chip select falling starts a new frame
// - all fields travel most significant bit first
// - chip select rise ends transfer, drops partials
// - direction bit then address; high means read
// - seven-bit address, fifteen when short bit clear
// - single mode: instruction per access; stream: one
// - write lands on edge of final bit
// - read data shifts from first data edge
// - short write byte ignored, bit count fault
// - multibyte registers span adjacent addresses
// - whole word write lock reads one always
// - split multibyte write ignored, incomplete fault
// - two-byte write commits at sixteenth edge
// - descending: msb first, then lower addresses
// - ascending: lsb first, then higher addresses
// - byte-wise multibyte read allowed but flagged
// - direction bit zero decrements, one increments
// - writes to registers from 0x29 need descending addressing
// - reference select picks source and pin mode
// - internal reference on, pin floating at reset
// - amplifier on after reset, shutdown bit disables
// - single mode expects new instruction per register
// - streaming steps address after every byte
`timescale 1ns/100ps
`include "dac_spi_defs.svh"
module dac_spi_register_access
    import dac_spi_pkg::*;
#(
    parameter logic [15:0] MAKER_ID = 16'h5a3c // arbitrary value
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    output logic ref_internal_en,
    output logic ref_pin_drive,
    output logic ref_external_sel,
    output logic amp_enable,
    output logic [15:0] dac_code
);
    logic [2:0] pin_lvl;
    logic [2:0] pin_prev;
    logic cs_s;
    logic sdi_s;
    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;
    frame_state_e state;
    logic [3:0] bit_cnt;
    logic [14:0] ishift;
    logic [6:0] rx;
    logic [7:0] tx;
    logic rw;
    logic [14:0] addr;
    logic addr_asc;
    logic single_instr;
    logic short_instr;
    logic [1:0] ref_sel;
    logic shutdown;
    logic [7:0] stage;
    logic mb_open;
    logic bit_count_fault;
    logic incomplete_word_fault;
    logic [15:0] instr_word;
    logic [7:0] rx_byte;
    logic instr_done;
    logic byte_done;
    logic wr_now;
    logic mb_first;
    logic mb_second;
    logic mb_fault;
    logic bc_fault;
    logic [14:0] next_addr;
    logic [14:0] new_addr;
    logic [7:0] cfg_c_val;

    // ============================================================
    // pin synchronisation, order {sdi, sclk, cs_n}
    pin_sync #(
        .W(3),
        .RST_VAL(3'h1)
    ) u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .pin({sdi, sclk, cs_n}),
        .lvl(pin_lvl),
        .prev(pin_prev)
    );

    // edges found on synchronised copies only
    assign cs_s = pin_lvl[0];
    assign sdi_s = pin_lvl[2];
    assign cs_fall = !pin_lvl[0] && pin_prev[0];
    assign cs_rise = pin_lvl[0] && !pin_prev[0];
    assign sclk_rise = pin_lvl[1] && !pin_prev[1];
    assign sclk_fall = !pin_lvl[1] && pin_prev[1];

    // ============================================================
    // decode helpers
    function automatic logic [7:0] rd_byte(input logic [14:0] a);
        if (a == `OFS_CFG_A) begin
            rd_byte = 8'h00 | (8'(addr_asc) << `POS_ADDR_ASC);
        end else if (a == `OFS_CFG_B) begin
            rd_byte = (8'(single_instr) << `POS_SINGLE_INSTR)
                | (8'(short_instr) << `POS_SHORT_INSTR);
        end else if (a == `OFS_CFG_C) begin
            rd_byte = 8'h01 << `POS_WRITE_LOCK;
        end else if (a == `OFS_STATUS) begin
            rd_byte = (8'(bit_count_fault) << `POS_BIT_COUNT_FAULT)
                | (8'(incomplete_word_fault) << `POS_INCOMPLETE_FAULT);
        end else if (a == `OFS_REF_CFG) begin
            rd_byte = {6'h00, ref_sel};
        end else if (a == `OFS_POWER) begin
            rd_byte = 8'(shutdown) << `POS_SHUTDOWN;
        end else if (a == `OFS_MAKER_LSB) begin
            rd_byte = MAKER_ID[7:0];
        end else if (a == `OFS_MAKER_MSB) begin
            rd_byte = MAKER_ID[15:8];
        end else if (a == `OFS_DAC_LSB) begin
            rd_byte = dac_code[7:0];
        end else if (a == `OFS_DAC_MSB) begin
            rd_byte = dac_code[15:8];
        end else begin
            rd_byte = 8'h00;
        end
    endfunction

    // first byte of a multibyte register in the given direction
    function automatic logic is_mb_first(input logic [14:0] a,
                                         input logic asc);
        if (asc) begin
            is_mb_first = (a == `OFS_MAKER_LSB) || (a == `OFS_DAC_LSB);
        end else begin
            is_mb_first = (a == `OFS_MAKER_MSB) || (a == `OFS_DAC_MSB);
        end
    endfunction

    function automatic logic is_mb_second(input logic [14:0] a,
                                          input logic asc);
        if (asc) begin
            is_mb_second = (a == `OFS_MAKER_MSB) || (a == `OFS_DAC_MSB);
        end else begin
            is_mb_second = (a == `OFS_MAKER_LSB) || (a == `OFS_DAC_LSB);
        end
    endfunction

    // ============================================================
    // per-edge strobes
    assign instr_word = {ishift, sdi_s};
    assign rx_byte = {rx, sdi_s};
    assign instr_done = (state == st_instr) && sclk_rise
        && (bit_cnt == (short_instr ? `LAST_BIT_SHORT : `LAST_BIT_LONG));
    assign byte_done = (state == st_data) && sclk_rise
        && (bit_cnt == `LAST_BIT_BYTE);
    assign wr_now = byte_done && !rw;
    assign mb_first = is_mb_first(addr, addr_asc);
    assign mb_second = is_mb_second(addr, addr_asc);
    // short instruction keeps the upper address bits at zero
    assign new_addr = short_instr ? {8'h00, instr_word[6:0]}
                                  : instr_word[14:0];

    // address step with wrap at the ends of the map
    always_comb begin
        if (addr_asc) begin
            next_addr = (addr == `OFS_TOP) ? 15'h0000 : addr + 15'h0001;
        end else begin
            next_addr = (addr == 15'h0000) ? `OFS_TOP : addr - 15'h0001;
        end
    end

    // ============================================================
    // frame sequencing
    // cs high forces idle so a new frame never inherits half an instruction
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= st_idle;
            bit_cnt <= 4'h0;
            ishift <= 15'h0000;
            rx <= 7'h00;
            tx <= 8'h00;
            rw <= 1'b0;
            addr <= 15'h0000;
        end else if (cs_s) begin
            state <= st_idle;
            bit_cnt <= 4'h0;
        end else begin
            case (state)
                st_idle: begin
                    state <= st_instr;
                    bit_cnt <= 4'h0;
                end
                st_instr: begin
                    if (sclk_rise) begin
                        ishift <= instr_word[14:0];
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    if (instr_done) begin
                        rw <= short_instr ? instr_word[7]
                                          : instr_word[15];
                        addr <= new_addr;
                        tx <= rd_byte(new_addr);
                        bit_cnt <= 4'h0;
                        state <= st_data;
                    end
                end
                st_data: begin
                    if (sclk_rise) begin
                        rx <= rx_byte[6:0];
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    if (byte_done) begin
                        bit_cnt <= 4'h0;
                        addr <= next_addr;
                        tx <= rd_byte(next_addr);
                        // a multibyte register counts as one access
                        if (single_instr && !mb_first) begin
                            state <= st_instr;
                        end
                    end else if (sclk_fall && rw) begin
                        tx <= {tx[6:0], 1'b0};
                    end
                end
                default: begin
                    state <= st_idle;
                end
            endcase
        end
    end

    // ============================================================
    // read data pin, updated on falling sclk
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sdo <= 1'b0;
        end else if (state == st_data && rw && sclk_fall && !cs_s) begin
            sdo <= tx[7];
        end
    end

    assign sdo_oe = !cs_s && (state == st_data) && rw;

    // ============================================================
    // multibyte tracking: both bytes must pass in one frame
    always_comb begin
        mb_fault = 1'b0;
        if (byte_done) begin
            if (mb_first) begin
                mb_fault = mb_open;
            end else if (mb_second) begin
                mb_fault = !mb_open;
            end else begin
                mb_fault = mb_open;
            end
            // ascending write to the upper block is never accepted
            if (!rw && addr_asc
                && (addr == `OFS_DAC_LSB || addr == `OFS_DAC_MSB)) begin
                mb_fault = 1'b1;
            end
        end else if (cs_rise && mb_open) begin
            mb_fault = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mb_open <= 1'b0;
            stage <= 8'h00;
        end else if (cs_rise) begin
            mb_open <= 1'b0;
        end else if (byte_done) begin
            mb_open <= mb_first;
            if (mb_first) begin
                stage <= rx_byte;
            end
        end
    end

    assign bc_fault = cs_rise && (state == st_data) && !rw
        && (bit_cnt != 4'h0);

    // ============================================================
    // configuration registers written over the link
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_asc <= `RST_ADDR_ASC;
            single_instr <= `RST_SINGLE_INSTR;
            short_instr <= `RST_SHORT_INSTR;
            ref_sel <= `RST_REF_SEL;
            shutdown <= `RST_SHUTDOWN;
        end else if (wr_now) begin
            if (addr == `OFS_CFG_A) begin
                addr_asc <= rx_byte[`POS_ADDR_ASC];
            end else if (addr == `OFS_CFG_B) begin
                single_instr <= rx_byte[`POS_SINGLE_INSTR];
                short_instr <= rx_byte[`POS_SHORT_INSTR];
            end else if (addr == `OFS_REF_CFG) begin
                ref_sel <= rx_byte[1:0];
            end else if (addr == `OFS_POWER) begin
                shutdown <= rx_byte[`POS_SHUTDOWN];
            end
        end
    end

    // dac code commits only as a whole, on the last data bit
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dac_code <= `RST_DAC_CODE;
        end else if (wr_now && !addr_asc && mb_open
                     && addr == `OFS_DAC_LSB) begin
            dac_code <= {stage, rx_byte};
        end
    end

    // ============================================================
    // status flags: write one to clear, a new fault wins
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bit_count_fault <= 1'b0;
            incomplete_word_fault <= 1'b0;
        end else begin
            bit_count_fault <= bc_fault || (bit_count_fault
                && !(wr_now && addr == `OFS_STATUS
                     && rx_byte[`POS_BIT_COUNT_FAULT]));
            incomplete_word_fault <= mb_fault || (incomplete_word_fault
                && !(wr_now && addr == `OFS_STATUS
                     && rx_byte[`POS_INCOMPLETE_FAULT]));
        end
    end

    // ============================================================
    // analog controls
    assign ref_internal_en = !ref_sel[1];
    assign ref_pin_drive = (ref_sel == 2'b01);
    assign ref_external_sel = ref_sel[1];
    assign amp_enable = !shutdown;

    // ============================================================
    // checks
    assign cfg_c_val = rd_byte(`OFS_CFG_C);

    a_frame_start: assert property (@(posedge clk) disable iff (!arst_n)
        cs_fall |=> state == st_instr)
        else $error("frame did not start on cs fall");

    a_cs_high_idle: assert property (@(posedge clk) disable iff (!arst_n)
        cs_s |=> state == st_idle && bit_cnt == 4'h0)
        else $error("state not cleared while cs high");

    a_short_instr: assert property (@(posedge clk) disable iff (!arst_n)
        state == st_instr && sclk_rise && !cs_s && short_instr
        && bit_cnt == 4'h7 |=> state == st_data)
        else $error("short instruction length wrong");

    a_sdo_msb: assert property (@(posedge clk) disable iff (!arst_n)
        state == st_data && rw && sclk_fall && !cs_s
        |=> sdo == $past(tx[7]))
        else $error("read bit not msb of shift register");

    a_dac_commit: assert property (@(posedge clk) disable iff (!arst_n)
        wr_now && !cs_s && !addr_asc && mb_open && addr == `OFS_DAC_LSB
        |=> dac_code == {$past(stage), $past(rx_byte)})
        else $error("dac code not committed whole");

    a_asc_block: assert property (@(posedge clk) disable iff (!arst_n)
        wr_now && addr_asc |=> $stable(dac_code))
        else $error("ascending write changed dac code");

    a_partial_flag: assert property (@(posedge clk) disable iff (!arst_n)
        mb_fault |=> incomplete_word_fault)
        else $error("incomplete word fault not raised");

    a_bitcnt_flag: assert property (@(posedge clk) disable iff (!arst_n)
        bc_fault |=> bit_count_fault ##1 bit_count_fault)
        else $error("bit count fault not raised");

    a_lock_reads_one: assert property (@(posedge clk) disable iff (!arst_n)
        cfg_c_val[`POS_WRITE_LOCK])
        else $error("write lock bit not one");

    a_amp_follow: assert property (@(posedge clk) disable iff (!arst_n)
        wr_now && !cs_s && addr == `OFS_POWER
        |=> amp_enable == !$past(rx_byte[`POS_SHUTDOWN]))
        else $error("amplifier enable did not follow write");

    a_ref_pin: assert property (@(posedge clk) disable iff (!arst_n)
        ref_pin_drive |-> ref_internal_en && !ref_external_sel)
        else $error("reference pin driven without internal source");

    a_addr_step: assert property (@(posedge clk) disable iff (!arst_n)
        byte_done && !cs_s && !addr_asc && addr != 15'h0000
        |=> addr == $past(addr) - 15'h0001)
        else $error("descending address did not step down");
endmodule // dac_spi_register_access

// [verif/spi_host_model.sv]
// host side of the serial link: frames, clocks and shifts bits.
// assumes mode 0 pacing from the 40 mhz clk, sclk period 200 ns.
`timescale 1ns/100ps
module spi_host_model (
    input wire logic clk,
    input wire logic sdo,
    output logic cs_n,
    output logic sclk,
    output logic sdi
);
    // ==========================================
    // pins at rest: cs high, sclk parked low
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end

    // half an sclk period, moved just past the clk edge
    task automatic half();
        repeat (4) @(posedge clk);
        #1;
    endtask

    // ==========================================
    // framing; sclk stands still between frames
    task automatic start();
        half();
        cs_n = 1'b0;
    endtask

    // sdi flipped after the last bit, before cs rises, so a stale level never looks valid
    task automatic stop();
        sclk = 1'b0;
        sdi = ~sdi;
        half();
        cs_n = 1'b1;
        half();
        half();
    endtask

    // n bits out msb first; sdo taken late in the high phase, since
    // the device moves sdo only some clk after each sclk fall
    task automatic shift(input logic [15:0] v, input int n,
                         output logic [15:0] r);
        r = '0;
        for (int i = n - 1; i >= 0; i--) begin
            sclk = 1'b0;
            sdi = v[i];
            half();
            sclk = 1'b1;
            half();
            r = {r[14:0], sdo};
        end
    endtask
endmodule // spi_host_model

// [verif/test_dac_spi_register_access.sv]
// self-checking bench of the serial register front end.
// assumes the host model drives the pins; registers via spi only.
`timescale 1ns/100ps
module test_dac_spi_register_access;
    localparam logic [15:0] MID = 16'hc3a5; // arbitrary maker value
    logic clk, arst_n, cs_n, sclk, sdi, sdo, sdo_oe;
    logic ref_internal_en, ref_pin_drive, ref_external_sel, amp_enable;
    logic [15:0] dac_code;
    logic [7:0] d, h;
    logic [15:0] r;
    int err_total = 0;
    int comparisons = 0;

    dac_spi_register_access #(.MAKER_ID(MID)) u_dac_spi_register_access (
        .clk(clk), .arst_n(arst_n), .cs_n(cs_n), .sclk(sclk),
        .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
        .ref_internal_en(ref_internal_en),
        .ref_pin_drive(ref_pin_drive),
        .ref_external_sel(ref_external_sel),
        .amp_enable(amp_enable), .dac_code(dac_code)
    );
    spi_host_model u_spi_host_model (
        .clk(clk), .sdo(sdo), .cs_n(cs_n), .sclk(sclk), .sdi(sdi)
    );

    // ==========================================
    // clock and watchdog
    initial clk = 1'b0;
    always #12.5 clk = ~clk;
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        give_verdict();
    end

    // ==========================================
    // compares and verdict
    task automatic chk_bit(input string nm, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic chk_word(input string nm, input logic [15:0] e,
                            input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ==========================================
    // access tasks: instruction byte is {rw, addr[6:0]}
    task automatic fo();
        u_spi_host_model.start();
    endtask
    task automatic fc();
        u_spi_host_model.stop();
    endtask
    task automatic sb(input logic [7:0] v);
        u_spi_host_model.shift({8'h00, v}, 8, r);
    endtask
    task automatic rb(output logic [7:0] v);
        u_spi_host_model.shift(16'h0000, 8, r);
        v = r[7:0];
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        fo();
        sb(a);
        sb(v);
        fc();
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        fo();
        sb({1'b1, a[6:0]});
        rb(v);
        fc();
    endtask
    // status fault bits only; the rest is left free
    task automatic chk_status(input logic [7:0] e);
        rd(8'h03, d);
        chk_word("status", {8'h00, e}, {8'h00, d & 8'h14});
    endtask

    // ==========================================
    // main sequence
    initial begin
        arst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        arst_n = 1'b1;
        chk_bit("amp_enable", 1'b1, amp_enable);
        chk_bit("ref_internal_en", 1'b1, ref_internal_en);
        chk_bit("ref_pin_drive", 1'b0, ref_pin_drive);
        chk_word("dac_code", 16'h0000, dac_code);
        chk_bit("sdo_oe", 1'b0, sdo_oe);
        rd(8'h02, d);
        chk_bit("write_lock", 1'b1, d[5]);
        // whole maker id, descending: msb first
        fo();
        sb(8'h8d);
        rb(h);
        chk_bit("sdo_oe", 1'b1, sdo_oe);
        rb(d);
        fc();
        chk_bit("sdo_oe", 1'b0, sdo_oe);
        chk_word("maker_id", MID, {h, d});
        chk_status(8'h00);
        // dac write commits only with the last bit of both bytes
        fo();
        sb(8'h2a);
        sb(8'h12);
        chk_word("dac_code", 16'h0000, dac_code);
        sb(8'h34);
        fc();
        chk_word("dac_code", 16'h1234, dac_code);
        // msb byte alone: dropped and flagged
        wr(8'h2a, 8'h56);
        chk_word("dac_code", 16'h1234, dac_code);
        chk_status(8'h04);
        wr(8'h03, 8'h04);
        chk_status(8'h00);
        // half a byte then cs rise
        fo();
        sb(8'h05);
        u_spi_host_model.shift(16'h000f, 4, r);
        fc();
        chk_bit("amp_enable", 1'b1, amp_enable);
        chk_status(8'h10);
        wr(8'h03, 8'h10);
        // streaming descending: 0x05 then 0x04
        fo();
        sb(8'h05);
        sb(8'h01);
        sb(8'h01);
        fc();
        chk_bit("amp_enable", 1'b0, amp_enable);
        chk_bit("ref_pin_drive", 1'b1, ref_pin_drive);
        for (int c = 0; c < 4; c++) begin
            wr(8'h04, c[7:0]);
            chk_bit("ref_int", c < 2, ref_internal_en);
            chk_bit("ref_pin", c == 1, ref_pin_drive);
            chk_bit("ref_ext", c[1], ref_external_sel);
        end
        // ascending: 0x04 then 0x05
        wr(8'h00, 8'h20);
        fo();
        sb(8'h04);
        sb(8'h02);
        sb(8'h00);
        fc();
        chk_bit("ref_ext", 1'b1, ref_external_sel);
        chk_bit("amp_enable", 1'b1, amp_enable);
        fo();
        sb(8'h29);
        sb(8'h78);
        sb(8'h9a);
        fc();
        chk_word("dac_code", 16'h1234, dac_code);
        chk_status(8'h04);
        wr(8'h03, 8'h04);
        fo();
        sb(8'h8c);
        rb(d);
        rb(h);
        fc();
        chk_word("maker_id", MID, {h, d});
        // one byte of a two-byte register read alone
        rd(8'h0c, d);
        chk_word("maker_lsb", {8'h00, MID[7:0]}, {8'h00, d});
        chk_status(8'h04);
        wr(8'h03, 8'h04);
        wr(8'h00, 8'h00);
        // single mode: an instruction before each register
        wr(8'h01, 8'h88);
        fo();
        sb(8'h05);
        sb(8'h01);
        sb(8'h04);
        sb(8'h01);
        fc();
        chk_bit("amp_enable", 1'b0, amp_enable);
        chk_bit("ref_pin_drive", 1'b1, ref_pin_drive);
        // fifteen-bit addressing, then back to seven
        wr(8'h01, 8'h80);
        fo();
        u_spi_host_model.shift(16'h0005, 16, r);
        sb(8'h00);
        u_spi_host_model.shift(16'h0001, 16, r);
        sb(8'h08);
        fc();
        chk_bit("amp_enable", 1'b1, amp_enable);
        rd(8'h01, d);
        chk_word("cfg_b", 16'h0008, {8'h00, d & 8'h88});
        give_verdict();
    end
endmodule // test_dac_spi_register_access
